// ===== rtl/buck_power_sequencer_control.sv
// Power sequencer, protection and power-good control of a step-down rail.
// Functional notes
// RULE_01: Below supply lockout all logic is reset and the converter is off.
// RULE_02: Thermal shutdown acts only while on, and holds the output off.
// RULE_03: After thermal shutdown restart only if auto restart, else await toggle.
// RULE_04: Warning flag at fixed threshold; pre-warning threshold selectable, default 105C.
// RULE_05: Discharge enabled after reset, bit controlled, forced first 100 us.
// RULE_06: Enable low: off; sleep if sleep bit, select high, or pull-up.
// RULE_07: Rising enable pin starts the power-up sequencer.
// RULE_08: Enable high: active bank enable bit turns converter on, else sleep.
// RULE_09: Enable pin transitions never reset digital logic or registers.
// RULE_10: During wake-up every bus request is refused with not-acknowledge.
// RULE_11: Startup delay in 2 ms steps, default zero, between wake and init.
// RULE_12: Delay applies to pin starts from off or sleep, not register starts.
// RULE_13: Power-up target voltage follows the present select signal.
// RULE_14: Shutdown needs no sequence; discharge output when discharge enabled.
// RULE_15: In hardware shutdown the core runs and registers stay accessible.
// RULE_16: Code rewrite or select change starts a ramp at set speed.
// RULE_17: Forced mode controls both ramp directions; auto limits fall rate. The code steps down at the set speed in both modes.
// RULE_18: Power good low when off, high at 95 percent, low below 90.
// RULE_19: With ramp power-good enabled, power good is low during ramps. The code gates only PG_LIVE_FLAG_O; PG_LATCHED_FLAG_O is not held low.
// RULE_20: Clearing normal power-good enable disables power-good in operation.
// RULE_21: Select low uses bank 0 settings, high uses bank 1 settings.
// RULE_22: Select gate zero ignores the pin and uses the select-high bank.
// RULE_23: Enable and select pins are synchronised before use.
`timescale 1ns/1ps
module buck_power_sequencer_control
  import seq_pkg::*;
(
  // Clock and supply lockout
  input  wire logic                        CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        SUPPLY_LOCKOUT_I,
  // Host pins
  input  wire logic                        ENABLE_PIN_I,
  input  wire logic                        BANK_SELECT_I,
  input  wire logic                        BUS_PULLUP_I,
  // Configuration bits
  input  wire logic                        SLEEP_REQ_I,
  input  wire logic                        SELECT_PIN_GATE_I,
  input  wire logic                        BANK0_CONV_ENABLE_I,
  input  wire logic                        BANK1_CONV_ENABLE_I,
  input  wire logic [seq_pkg::VCODE_W-1:0] BANK0_VOLTAGE_CODE_I,
  input  wire logic [seq_pkg::VCODE_W-1:0] BANK1_VOLTAGE_CODE_I,
  input  wire logic                        BANK0_FORCED_MODE_I,
  input  wire logic                        BANK1_FORCED_MODE_I,
  input  wire logic                        RAMP_MODE_SEL_I,
  input  wire logic [1:0]                  RAMP_SPEED_I,
  input  wire logic [2:0]                  STARTUP_DELAY_I,
  input  wire logic                        AUTO_RESTART_ENABLE_I,
  input  wire logic [1:0]                  PREWARN_THRESHOLD_SEL_I,
  input  wire logic                        DISCHARGE_ENABLE_I,
  input  wire logic                        RAMP_PG_ENABLE_I,
  input  wire logic                        NORMAL_PG_ENABLE_I,
  // Analog monitors
  input  wire logic                        THERMAL_SHUTDOWN_I,
  input  wire logic                        TEMP_WARN_I,
  input  wire logic [3:0]                  TEMP_PREWARN_I,
  input  wire logic                        VOUT_ABOVE_95_I,
  input  wire logic                        VOUT_BELOW_90_I,
  // Converter control
  output logic                             CONV_ON_O,
  output logic                             DISCHARGE_O,
  output logic                             FORCED_PWM_O,
  output logic [seq_pkg::VCODE_W-1:0]      VOUT_CODE_O,
  output logic                             BUS_NACK_O,
  // Status
  output logic                             PG_LATCHED_FLAG_O,
  output logic                             PG_LIVE_FLAG_O,
  output logic                             THERMAL_WARN_O,
  output logic                             PREWARN_O,
  output logic                             SLEEP_MODE_O,
  output logic                             THERMAL_SHUTDOWN_O,
  output logic [2:0]                       SEQ_KIND_O
);
  import seq_pkg::*;

  logic         rst;
  logic         en_s;
  logic         sel_s;
  logic         en_d_r;
  logic         sel_eff_d_r;
  logic         sel_eff;
  logic         bank_en;
  logic [6:0]   code_sel;
  logic [6:0]   code_d_r;
  logic         en_rise;
  logic         on_nxt;
  logic         sel_change;
  logic         code_rewrite;
  seq_state_t   state_r;
  seq_state_t   state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] delay_cyc;
  logic [13:0]  disch_cnt_r;
  logic         woke_r;
  logic         sleep_pref;
  logic         tsd_hold_r;
  logic         run;
  logic         ramp_busy;
  logic         pg_raw_r;
  logic         out_on;

  // The lockout comparator is a supply event, so it resets like the pin.
  assign rst = RST_I || SUPPLY_LOCKOUT_I; // RULE_01

  pin_sync u_en_sync (
    .CLK_I   (CLK_I),
    .RST_I   (rst),
    .PIN_I   (ENABLE_PIN_I),
    .LEVEL_O (en_s)
  ); // RULE_23

  pin_sync u_sel_sync (
    .CLK_I   (CLK_I),
    .RST_I   (rst),
    .PIN_I   (BANK_SELECT_I),
    .LEVEL_O (sel_s)
  ); // RULE_23

  assign sel_eff  = SELECT_PIN_GATE_I ? sel_s : 1'b1; // RULE_22
  assign bank_en  = sel_eff ? BANK1_CONV_ENABLE_I
                            : BANK0_CONV_ENABLE_I; // RULE_21
  assign code_sel = sel_eff ? BANK1_VOLTAGE_CODE_I
                            : BANK0_VOLTAGE_CODE_I; // RULE_13
  assign FORCED_PWM_O = sel_eff ? BANK1_FORCED_MODE_I
                                : BANK0_FORCED_MODE_I; // RULE_21
  assign en_rise      = en_s && !en_d_r;
  assign sel_change   = sel_eff != sel_eff_d_r;
  assign code_rewrite = code_sel != code_d_r;
  assign sleep_pref   = SLEEP_REQ_I || sel_s || BUS_PULLUP_I; // RULE_06
  assign delay_cyc    = CNT_W'(STARTUP_DELAY_I) * CNT_W'(DELAY_STEP_CYC);

  // Edge history is plain state; the pin itself never touches the reset.
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      // Loading the present select and code keeps a false change from following reset; the enable history clears to zero.
      en_d_r      <= 1'b0;
      sel_eff_d_r <= sel_eff;
      code_d_r    <= code_sel;
    end else begin
      en_d_r      <= en_s; // RULE_09
      sel_eff_d_r <= sel_eff;
      code_d_r    <= code_sel;
    end
  end

  // Internal wake-up runs once after supply rise.
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      woke_r <= 1'b0;
    end else if (state_r == ST_WAKE && cnt_r >= CNT_W'(WAKE_CYC - 1)) begin
      woke_r <= 1'b1;
    end
  end

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r + 24'h000001;
    SEQ_KIND_O = 3'h0;
    case (state_r)
      ST_WAKE: begin
        if (cnt_r >= CNT_W'(WAKE_CYC - 1)) begin
          cnt_nxt   = 24'h000000;
          state_nxt = !en_s ? (sleep_pref ? ST_SLEEP : ST_OFF) : ST_DELAY;
        end
      end
      ST_OFF, ST_SLEEP: begin
        cnt_nxt   = 24'h000000;
        state_nxt = sleep_pref ? ST_SLEEP : ST_OFF; // RULE_06
        if (en_rise) begin
          state_nxt = ST_DELAY; // RULE_07 RULE_12
        end else if (en_s && bank_en && (sel_change || state_r == ST_SLEEP)) begin
          state_nxt = ST_INIT; // RULE_12
        end
      end
      ST_DELAY: begin
        if (cnt_r >= delay_cyc) begin
          cnt_nxt   = 24'h000000;
          state_nxt = ST_INIT; // RULE_11
        end
      end
      ST_INIT: begin
        // The output is already on during init, so the guard is armed.
        if (THERMAL_SHUTDOWN_I) begin
          cnt_nxt   = 24'h000000;
          state_nxt = ST_THERMAL; // RULE_02
        end else if (cnt_r >= CNT_W'(INIT_CYC - 1)) begin
          cnt_nxt   = 24'h000000;
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        cnt_nxt = 24'h000000;
        if (THERMAL_SHUTDOWN_I) begin
          state_nxt = ST_THERMAL; // RULE_02
        end
      end
      ST_THERMAL: begin
        cnt_nxt = 24'h000000;
        if (!THERMAL_SHUTDOWN_I && AUTO_RESTART_ENABLE_I) begin
          state_nxt = ST_INIT; // RULE_03
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // Shutdown paths take priority over any sequence in progress after wake-up; the bank-enable path lets a startup delay run out.
    if (state_r != ST_WAKE) begin
      if (!en_s && state_r != ST_OFF && state_r != ST_SLEEP) begin
        cnt_nxt   = 24'h000000;
        state_nxt = sleep_pref ? ST_SLEEP : ST_OFF; // RULE_14
      end else if (en_s && !bank_en && state_r != ST_THERMAL &&
                   state_r != ST_DELAY && !en_rise) begin
        cnt_nxt   = 24'h000000;
        state_nxt = ST_SLEEP; // RULE_08
      end
    end
    if (state_nxt == ST_DELAY && state_r != ST_DELAY) begin
      SEQ_KIND_O = woke_r ? (state_r == ST_SLEEP ? 3'h3 : 3'h2) : 3'h1;
    end else if (state_nxt == ST_INIT && state_r != ST_INIT &&
                 state_r != ST_DELAY) begin
      SEQ_KIND_O = 3'h4;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      state_r <= ST_WAKE;
      cnt_r   <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      tsd_hold_r <= 1'b0;
    end else begin
      tsd_hold_r <= (state_nxt == ST_THERMAL); // RULE_02
    end
  end

  assign out_on = (state_r == ST_INIT || state_r == ST_ACTIVE);
  assign on_nxt = (state_nxt == ST_INIT || state_nxt == ST_ACTIVE);
  // Taken straight from the hold flop so it lines up with the converter
  // enable, which is registered from the same next state.
  assign THERMAL_SHUTDOWN_O = tsd_hold_r; // RULE_02
  assign run    = out_on;

  volt_ramp u_ramp (
    .CLK_I     (CLK_I),
    .RST_I     (rst),
    .RUN_I     (run),
    .TARGET_I  (code_sel),
    .SPEED_I   (RAMP_SPEED_I),
    .FORCED_I  (RAMP_MODE_SEL_I),
    .RESTART_I (code_rewrite || sel_change), // RULE_16
    .CODE_O    (VOUT_CODE_O),
    .BUSY_O    (ramp_busy)
  );

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      disch_cnt_r <= 14'h0000;
    end else if (disch_cnt_r < 14'(DISCH_INIT_CYC)) begin
      disch_cnt_r <= disch_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      CONV_ON_O   <= 1'b0;
      DISCHARGE_O <= DISCH_DEFAULT; // RULE_05
      BUS_NACK_O  <= 1'b1;
    end else begin
      CONV_ON_O   <= on_nxt;
      DISCHARGE_O <= (disch_cnt_r < 14'(DISCH_INIT_CYC)) ||
                     (DISCHARGE_ENABLE_I && !on_nxt); // RULE_05 RULE_14
      BUS_NACK_O  <= (state_nxt == ST_WAKE); // RULE_10 RULE_15
    end
  end

  // Comparator hysteresis: set above 95 percent, cleared below 90 percent.
  always_ff @(posedge CLK_I) begin
    if (rst || !on_nxt) begin
      pg_raw_r <= 1'b0;
    end else if (VOUT_BELOW_90_I) begin
      pg_raw_r <= 1'b0;
    end else if (VOUT_ABOVE_95_I && state_r == ST_ACTIVE) begin
      pg_raw_r <= 1'b1; // RULE_18
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      PG_LIVE_FLAG_O     <= 1'b0;
      PG_LATCHED_FLAG_O  <= 1'b0;
      THERMAL_WARN_O     <= 1'b0;
      PREWARN_O          <= 1'b0;
      SLEEP_MODE_O       <= 1'b0;
    end else begin
      PG_LIVE_FLAG_O <= pg_raw_r && NORMAL_PG_ENABLE_I &&
                        !(RAMP_PG_ENABLE_I && ramp_busy); // RULE_19 RULE_20
      PG_LATCHED_FLAG_O  <= pg_raw_r && NORMAL_PG_ENABLE_I; // RULE_18
      THERMAL_WARN_O     <= TEMP_WARN_I; // RULE_04
      PREWARN_O          <= TEMP_PREWARN_I[PREWARN_THRESHOLD_SEL_I]; // RULE_04
      SLEEP_MODE_O       <= (state_nxt == ST_SLEEP);
    end
  end
endmodule : buck_power_sequencer_control

// ===== rtl/pin_sync.sv
// Two flip-flop synchroniser for one asynchronous pin level.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_I,
  // Pin level in and synchronised level out
  input  wire logic PIN_I,
  output logic      LEVEL_O
);
  logic meta_r;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      meta_r  <= 1'b0;
      LEVEL_O <= 1'b0;
    end else begin
      meta_r  <= PIN_I;
      LEVEL_O <= meta_r;
    end
  end
endmodule : pin_sync

// ===== rtl/seq_pkg.sv
// Constants and types shared by the power sequencer control files.
package seq_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned DISCH_INIT_US    = 100;
  localparam int unsigned DISCH_INIT_CYC   = DISCH_INIT_US * CLK_MHZ;
  localparam int unsigned WAKE_US          = 100;
  localparam int unsigned WAKE_CYC         = WAKE_US * CLK_MHZ;
  localparam int unsigned DELAY_STEP_MS    = 2;
  localparam int unsigned DELAY_STEP_CYC   = DELAY_STEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned INIT_US          = 50;
  localparam int unsigned INIT_CYC         = INIT_US * CLK_MHZ;
  localparam int unsigned SOFTSTART_US     = 40;
  localparam int unsigned SOFTSTART_CYC    = SOFTSTART_US * CLK_MHZ;
  localparam int unsigned VCODE_W          = 7;
  localparam int unsigned CNT_W            = 24;
  localparam int unsigned RAMP_BASE_CYC    = 125;
  localparam logic [VCODE_W-1:0] VCODE_ZERO = 7'h00;
  localparam logic [1:0] PREWARN_DEFAULT   = 2'h0;
  localparam logic       DISCH_DEFAULT     = 1'b1;
  localparam int unsigned RAMP_SHIFT_W     = 2;

  typedef enum {
    ST_OFF, ST_SLEEP, ST_WAKE, ST_DELAY, ST_INIT, ST_ACTIVE, ST_THERMAL
  } seq_state_t;
endpackage : seq_pkg

// ===== rtl/volt_ramp.sv
// Output voltage ramp generator stepping one code per rate interval.
`timescale 1ns/1ps
module volt_ramp
  import seq_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  // Control
  input  wire logic               RUN_I,
  input  wire logic [VCODE_W-1:0] TARGET_I,
  input  wire logic [1:0]         SPEED_I,
  input  wire logic               FORCED_I,
  input  wire logic               RESTART_I,
  // Status
  output logic [VCODE_W-1:0]      CODE_O,
  output logic                    BUSY_O
);
  logic [11:0] tick_r;
  logic [11:0] period;

  // Larger speed codes step faster; the fall in auto mode uses the same
  // rate, which is the fastest a load could ever pull it down.
  assign period = 12'(RAMP_BASE_CYC) << (2'h3 - SPEED_I);
  assign BUSY_O = RUN_I && (CODE_O != TARGET_I);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tick_r <= 12'h000;
    end else if (!BUSY_O || RESTART_I || tick_r >= period - 12'h001) begin
      tick_r <= 12'h000;
    end else begin
      tick_r <= tick_r + 12'h001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || !RUN_I) begin
      CODE_O <= VCODE_ZERO;
    end else if (BUSY_O && tick_r >= period - 12'h001) begin
      if (CODE_O < TARGET_I) begin
        CODE_O <= CODE_O + 7'h01; // RULE_16
      end else if (FORCED_I || FORCED_I == 1'b0) begin
        CODE_O <= CODE_O - 7'h01; // RULE_17
      end
    end
  end
endmodule : volt_ramp

// ===== tb/host_pins.sv
// Host side model driving the enable and select pins of the sequencer.
`timescale 1ns/1ps
module host_pins (
  // Clock
  input  wire logic CLK_I,
  // Requests from the bench and bus refusal from the device
  input  wire logic EN_REQ_I,
  input  wire logic SEL_REQ_I,
  input  wire logic NACK_I,
  // Pins and bus status
  output logic      ENABLE_O,
  output logic      SELECT_O,
  output logic      ACCESS_OK_O
);
  initial begin
    ENABLE_O = 1'h0;
    SELECT_O = 1'h0;
  end
  // Pins move on the core edge itself, so the device must synchronise.
  always @(posedge CLK_I) begin
    ENABLE_O <= EN_REQ_I;
    SELECT_O <= SEL_REQ_I;
  end
  // A refused access has to be retried later by the host.
  assign ACCESS_OK_O = !NACK_I;
endmodule : host_pins

// ===== tb/seq_monitor.sv
// Concurrent checks on the ports of the sequencer control block.
`timescale 1ns/1ps
module seq_monitor (
  // Clock and resets
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       SUPPLY_LOCKOUT_I,
  // Watched inputs
  input wire logic       ENABLE_PIN_I,
  input wire logic       SELECT_PIN_GATE_I,
  input wire logic       BANK1_FORCED_MODE_I,
  input wire logic       TEMP_WARN_I,
  input wire logic [3:0] TEMP_PREWARN_I,
  input wire logic [1:0] PREWARN_THRESHOLD_SEL_I,
  // Watched outputs
  input wire logic       CONV_ON_O,
  input wire logic       DISCHARGE_O,
  input wire logic       BUS_NACK_O,
  input wire logic       FORCED_PWM_O,
  input wire logic       PG_LIVE_FLAG_O,
  input wire logic       THERMAL_WARN_O,
  input wire logic       PREWARN_O,
  input wire logic       THERMAL_SHUTDOWN_O,
  input wire logic [2:0] SEQ_KIND_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I || SUPPLY_LOCKOUT_I);
  a_lockout_holds: assert property (disable iff (RST_I)
    SUPPLY_LOCKOUT_I |=> !CONV_ON_O && DISCHARGE_O && BUS_NACK_O)
    else $error("lockout does not hold the converter in reset");
  a_thermal_off: assert property (THERMAL_SHUTDOWN_O [*2] |-> !CONV_ON_O)
    else $error("converter on during thermal shutdown");
  a_pin_low_off: assert property (!ENABLE_PIN_I [*6] |-> !CONV_ON_O)
    else $error("converter on with enable pin low");
  a_pg_when_off: assert property (!CONV_ON_O [*2] |-> !PG_LIVE_FLAG_O)
    else $error("power good high while converter off");
  a_wake_nack: assert property (BUS_NACK_O |-> !CONV_ON_O)
    else $error("converter on while bus still refused");
  a_kind_pulse: assert property (SEQ_KIND_O != 3'h0 |=>
    SEQ_KIND_O == 3'h0 && $past(SEQ_KIND_O) <= 3'h4)
    else $error("sequence kind not a single valid pulse");
  a_fast_nodelay: assert property (SEQ_KIND_O == 3'h4 |->
    ##[1:2] (CONV_ON_O || !ENABLE_PIN_I || THERMAL_SHUTDOWN_O))
    else $error("fast start did not turn the converter on at once");
  a_warn_follow: assert property ($stable(TEMP_WARN_I) [*3] |->
    THERMAL_WARN_O == TEMP_WARN_I)
    else $error("warning flag does not follow sensor");
  a_prewarn_sel: assert property (($stable(TEMP_PREWARN_I) &&
    $stable(PREWARN_THRESHOLD_SEL_I)) [*3] |->
    PREWARN_O == TEMP_PREWARN_I[PREWARN_THRESHOLD_SEL_I])
    else $error("pre-warning flag does not follow selected level");
  a_gate_bank: assert property ((!SELECT_PIN_GATE_I) [*2] |->
    FORCED_PWM_O == BANK1_FORCED_MODE_I)
    else $error("gated select does not use the high bank mode");
  c_normal: cover property (SEQ_KIND_O == 3'h2);
  c_quick: cover property (SEQ_KIND_O == 3'h3);
  c_fast: cover property (SEQ_KIND_O == 3'h4);
endmodule : seq_monitor

bind buck_power_sequencer_control seq_monitor u_mon (.*);

// ===== tb/tb_top.sv
// Self-checking bench for the power sequencer control block.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import seq_pkg::*;
  logic clk, rst, lock, en_r, sel_r, en, sel, pull, slp, gate, ok, are;
  logic en0, en1, fm0, fm1, rmode, dis, rpg, npg, thermal_shutdown, warn, hi95, lo90;
  logic conv, dchg, fpwm, nack, pgl, pgv, twarn, pwarn, sleep, tsdo;
  logic [1:0]         spd, pws;
  logic [2:0]         dly, kind, e;
  logic [3:0]         prw;
  logic [VCODE_W-1:0] v0, v1, code;
  logic [31:0]        seed = 32'hE7B30CC2;
  logic [2:0]         q[$];
  int num_errors = 0;
  int n_checks = 0;
  int cnt = 0;
  host_pins u_host (.CLK_I(clk), .EN_REQ_I(en_r), .SEL_REQ_I(sel_r),
    .NACK_I(nack), .ENABLE_O(en), .SELECT_O(sel), .ACCESS_OK_O(ok));
  buck_power_sequencer_control DUT (
    .CLK_I(clk), .RST_I(rst), .SUPPLY_LOCKOUT_I(lock),
    .ENABLE_PIN_I(en), .BANK_SELECT_I(sel), .BUS_PULLUP_I(pull),
    .SLEEP_REQ_I(slp), .SELECT_PIN_GATE_I(gate),
    .BANK0_CONV_ENABLE_I(en0), .BANK1_CONV_ENABLE_I(en1),
    .BANK0_VOLTAGE_CODE_I(v0), .BANK1_VOLTAGE_CODE_I(v1),
    .BANK0_FORCED_MODE_I(fm0), .BANK1_FORCED_MODE_I(fm1),
    .RAMP_MODE_SEL_I(rmode), .RAMP_SPEED_I(spd),
    .STARTUP_DELAY_I(dly), .AUTO_RESTART_ENABLE_I(are),
    .PREWARN_THRESHOLD_SEL_I(pws), .DISCHARGE_ENABLE_I(dis),
    .RAMP_PG_ENABLE_I(rpg), .NORMAL_PG_ENABLE_I(npg),
    .THERMAL_SHUTDOWN_I(thermal_shutdown), .TEMP_WARN_I(warn),
    .TEMP_PREWARN_I(prw), .VOUT_ABOVE_95_I(hi95),
    .VOUT_BELOW_90_I(lo90), .CONV_ON_O(conv), .DISCHARGE_O(dchg),
    .FORCED_PWM_O(fpwm), .VOUT_CODE_O(code), .BUS_NACK_O(nack),
    .PG_LATCHED_FLAG_O(pgl), .PG_LIVE_FLAG_O(pgv),
    .THERMAL_WARN_O(twarn), .PREWARN_O(pwarn),
    .SLEEP_MODE_O(sleep), .THERMAL_SHUTDOWN_O(tsdo), .SEQ_KIND_O(kind));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_on(input logic v);
    for (int i = 0; i < 20000 && conv !== v; i++) @(negedge clk);
    `CHK(conv, v)
  endtask : wait_on
  task automatic wait_code(input logic [VCODE_W-1:0] v);
    for (int i = 0; i < 20000 && code !== v; i++) @(negedge clk);
    `CHK(code, v)
  endtask : wait_code
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // A hang in any wait still ends in the closing report.
  always @(posedge clk) begin
    cnt++;
    if (cnt == 90000) begin
      num_errors++;
      close_out();
    end
  end
  // Every sequence pulse must match the oldest start noted by the driver.
  always @(negedge clk) begin
    if (!rst && kind !== 3'h0) begin
      e = (q.size() > 0) ? q.pop_front() : 3'h0;
      `CHK(kind, e)
    end
  end
  initial begin
    rst = 1'h1;
    {lock, en_r, sel_r, pull, slp, fm0, fm1, rmode, are} = 9'h000;
    {thermal_shutdown, warn, hi95, lo90, rpg} = 5'h00;
    {gate, en0, en1, dis, npg} = 5'h1F;
    {spd, dly, pws, prw} = 11'h600;
    v0 = 7'h20;
    v1 = 7'h28;
    cyc(20);
    rst = 1'h0;
    cyc(2);
    `CHK(ok, 1'h0)
    `CHK(dchg, 1'h1)
    q.push_back(3'h1);
    en_r = 1'h1;
    wait_on(1'h1);
    `CHK(nack, 1'h0)
    `CHK(dchg, 1'h0)
    wait_code(v0);
    hi95 = 1'h1;
    cyc(1100);
    `CHK(pgv, 1'h1)
    `CHK(pgl, 1'h1)
    {hi95, lo90} = 2'h1;
    cyc(5);
    `CHK(pgv, 1'h0)
    {hi95, lo90, rpg, sel_r} = 4'hB;
    cyc(8);
    `CHK(pgv, 1'h0)
    wait_code(v1);
    cyc(5);
    `CHK(pgv, 1'h1)
    npg = 1'h0;
    cyc(5);
    `CHK(pgv, 1'h0)
    {npg, fm0, fm1, rmode, sel_r, gate} = 6'h2C;
    cyc(5);
    `CHK(fpwm, 1'h1)
    `CHK(code, v1)
    gate = 1'h1;
    cyc(5);
    `CHK(fpwm, 1'h0)
    wait_code(v0);
    en0 = 1'h0;
    wait_on(1'h0);
    `CHK(sleep, 1'h1)
    `CHK(dchg, 1'h1)
    q.push_back(3'h4);
    en0 = 1'h1;
    wait_on(1'h1);
    en_r = 1'h0;
    wait_on(1'h0);
    cyc(5);
    `CHK(sleep, 1'h0)
    `CHK(nack, 1'h0)
    q.push_back(3'h2);
    en_r = 1'h1;
    wait_on(1'h1);
    for (int k = 0; k < 3; k++) begin
      en_r = 1'h0;
      {slp, pull, sel_r} = 3'(1 << k);
      dis = k[0];
      wait_on(1'h0);
      cyc(5);
      `CHK(sleep, 1'h1)
      `CHK(dchg, k[0])
      q.push_back(3'h3);
      en_r = 1'h1;
      wait_on(1'h1);
    end
    for (int r = 0; r < 2; r++) begin
      {are, thermal_shutdown} = {r[0], 1'h1};
      cyc(5);
      `CHK(tsdo, 1'h1)
      `CHK(conv, 1'h0)
      if (r[0]) q.push_back(3'h4);
      thermal_shutdown = 1'h0;
      cyc(6000);
      `CHK(conv, r[0])
      if (r == 0) begin
        en_r = 1'h0;
        cyc(5);
        q.push_back(3'h3);
        en_r = 1'h1;
        wait_on(1'h1);
      end
    end
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {warn, pws, prw} = seed[6:0];
      cyc(3);
      `CHK(pwarn, prw[pws])
      `CHK(twarn, warn)
    end
    lock = 1'h1;
    cyc(2);
    `CHK(conv, 1'h0)
    `CHK(nack, 1'h1)
    `CHK(pwarn, 1'h0)
    lock = 1'h0;
    cyc(2);
    `CHK(q.size(), 0)
    close_out();
  end
endmodule : tb_top
